// ### design/idle_domain_configuration.sv
// Idle configuration register with APB access, idle-instruction apply and bus error interrupt
// Function
// [R1] - Requests are only stored; they take effect when the idle instruction executes; code also applies them on an idle command write with bit 0 set.
// [R2] - Software sets confirm bit 9 together with clock-generator idle bit.
// [R3] - Both clock bits zero keeps clock running; both one stops it.
// [R4] - Clock idle without confirm bit at idle instruction raises bus error.
// [R5] - Clock idle needs confirm, core, master, cache, memory and port bits set.
// [R6] - Legal clock-generator idle stops the system clock, deepest power state.
// [R7] - Bit 8 idles cache bus port after idle instruction; resets to zero.
// [R8] - Bit 7 idles master bus port after idle instruction; resets to zero.
// [R9] - Bit 6 idles I/O bus port after idle instruction; resets to zero.
// [R10] - Bit 5 idles external memory interface after idle instruction; resets zero.
// [R11] - Bit 3 idles peripherals flagged in peripheral idle control only.
// [R12] - Bits 2,1,0 idle instruction cache, master peripherals and core.
// [R13] - Bits 15 to 10 read zero and ignore writes.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`include "idle_domain_params.svh"
module idle_domain_configuration #(
   parameter int PERIPH_COUNT = 16  // Peripheral idle flags; the readback field holds at most 16
) (
   input  wire logic                         core_clk,        // System clock, 20 MHz
   input  wire logic                         rst,             // Asynchronous reset, active high
   input  wire logic                         psel,            // APB select
   input  wire logic                         penable,         // APB access phase
   input  wire logic                         pwrite,          // APB direction
   input  wire logic [11:0]                  paddr,           // APB byte address
   input  wire logic [31:0]                  pwdata,          // APB write data
   input  wire logic [3:0]                   pstrb,           // APB byte strobes
   output logic      [31:0]                  prdata,          // APB read data
   output logic                              pready,          // APB ready
   output logic                              pslverr,         // APB error on unmapped address
   input  wire logic                         idleInstr,       // Idle instruction pulse from core
   input  wire logic [PERIPH_COUNT-1:0]      peripheralIdleControl, // Per-peripheral idle flags
   output idle_domain_pkg::domain_ctrl_t     domainCtrl,      // Applied domain controls
   output logic      [PERIPH_COUNT-1:0]      peripheralOff,   // Peripherals held in idle
   output logic                              busErrorIrq      // Level interrupt
);
   // Register state
   logic [15:0]                     cfg_q, cfg_d;
   logic [`IDC_IRQ_WIDTH-1:0]       status_q, status_d;
   logic [`IDC_IRQ_WIDTH-1:0]       mask_q, mask_d;
   idle_domain_pkg::domain_ctrl_t   applied_q, applied_d;
   logic [PERIPH_COUNT-1:0]         periOff_q, periOff_d;
   idle_domain_pkg::idle_state_t    state_q, state_d;
   logic [31:0]                     rdata_q, rdata_d;
   logic                            ready_q, ready_d;
   logic                            err_q, err_d;
   logic                            irq_q, irq_d;
   logic [15:0]                     snap_q, snap_d;
   logic                            badCombo;
   logic                            stopClock;
   logic                            access;
   logic                            wrEn;
   logic                            mapped;
   logic [`IDC_IRQ_WIDTH-1:0]       events;
   logic [PERIPH_COUNT-1:0]         periGate;
   logic [15:0]                     periOffWord;
   logic                            cfgSel;
   logic                            maskSel;
   logic                            statusSel;
   logic                            idleCmdSel;

   // Readback packs the flags into one 16-bit field; more would not fit
   if (PERIPH_COUNT < 1 || PERIPH_COUNT > 16) begin : g_bad_count
      $error("PERIPH_COUNT must lie between 1 and 16");
   end

   // Per-peripheral gate: a flag idles its peripheral only while the group bit is set
   for (genvar p = 0; p < PERIPH_COUNT; p++) begin : g_periph
      assign periGate[p] = snap_q[`IDC_BIT_PERIPH] && peripheralIdleControl[p]; // [R11]
   end

   // Check runs on the snapshot so a write landing mid-apply cannot tear it
   idle_request_check u_check (
      .cfgWord   (snap_q),
      .badCombo  (badCombo),
      .stopClock (stopClock)
   );

   // Bus decode; two-cycle access phase, answer registered on the first access edge
   always_comb begin
      access = psel && penable && !ready_q;
      wrEn   = access && pwrite;
      // Shared address compares, so each register group decodes the same way
      cfgSel     = (paddr == `IDC_CFG_ADDR);
      maskSel    = (paddr == `IDC_IRQ_MASK_ADDR);
      statusSel  = (paddr == `IDC_IRQ_STATUS_ADDR);
      idleCmdSel = (paddr == `IDC_IDLE_CMD_ADDR);
      case (paddr)
         `IDC_CFG_ADDR,
         `IDC_APPLIED_ADDR,
         `IDC_IRQ_STATUS_ADDR,
         `IDC_IRQ_MASK_ADDR,
         `IDC_IDLE_CMD_ADDR: mapped = 1'b1;
         default:            mapped = 1'b0;
      endcase
   end

   // Idle sequencing: snapshot, check, apply
   always_comb begin
      state_d   = state_q;
      snap_d    = snap_q;
      applied_d = applied_q;
      periOff_d = periOff_q;
      events    = '0;
      case (state_q)
         idle_domain_pkg::ST_RUN: begin
            // Stored bits stay inert until the idle instruction or an idle command write with bit 0 set
            if (idleInstr || (wrEn && idleCmdSel && pwdata[0])) begin // [R1]
               snap_d  = cfg_q;
               state_d = idle_domain_pkg::ST_CHECK;
            end
         end
         idle_domain_pkg::ST_CHECK: begin
            if (badCombo) begin
               // Illegal set: refuse to stop the clock, flag the bus error
               events[`IDC_IRQ_BUS_ERROR] = 1'b1;                   // [R4] [R5]
               state_d = idle_domain_pkg::ST_RUN;
            end else begin
               state_d = idle_domain_pkg::ST_APPLY;
            end
         end
         idle_domain_pkg::ST_APPLY: begin
            applied_d.clockStop       = stopClock;                    // [R3] [R6]
            applied_d.cachePortOff    = snap_q[`IDC_BIT_CACHE_PORT];  // [R7]
            applied_d.masterPortOff   = snap_q[`IDC_BIT_MASTER_PORT]; // [R8]
            applied_d.ioPortOff       = snap_q[`IDC_BIT_IO_PORT];     // [R9]
            applied_d.extMemOff       = snap_q[`IDC_BIT_EXTMEM];      // [R10]
            applied_d.periphGroupOff  = snap_q[`IDC_BIT_PERIPH];      // [R11]
            applied_d.cacheOff        = snap_q[`IDC_BIT_CACHE];       // [R12]
            applied_d.masterPeriphOff = snap_q[`IDC_BIT_MASTER_PERIPHERAL_GROUP_IDLE_REQUEST]; // [R12]
            applied_d.coreOff         = snap_q[`IDC_BIT_CORE];        // [R12]
            // Only flagged peripherals idle; zero wakes them all
            periOff_d = periGate;                                       // [R11]
            events[`IDC_IRQ_IDLE_DONE] = 1'b1;
            state_d = idle_domain_pkg::ST_RUN;
         end
         default: state_d = idle_domain_pkg::ST_RUN;
      endcase
   end

   // Configuration register; reserved bits never latch, so they read back zero
   always_comb begin
      cfg_d = cfg_q;
      if (wrEn && cfgSel) begin
         // Byte lanes let software touch one half without a read-modify-write
         if (pstrb[0]) begin
            cfg_d[7:0] = pwdata[7:0];
         end
         if (pstrb[1]) begin
            cfg_d[15:8] = pwdata[15:8];
         end
         cfg_d = cfg_d & `IDC_CFG_WRITE_MASK;                          // [R13]
      end
   end

   // Configuration flops; every domain stays awake out of reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg_q <= `IDC_CFG_RESET;                                      // [R7] [R8] [R9] [R10]
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // Sticky status and mask; a new event in the same cycle beats the clear
   always_comb begin
      mask_d   = mask_q;
      status_d = status_q;
      if (wrEn && maskSel && pstrb[0]) begin
         mask_d = pwdata[`IDC_IRQ_WIDTH-1:0];
      end
      // Write one to clear, so a read-modify-write cannot lose a fresh event
      if (wrEn && statusSel && pstrb[0]) begin
         status_d = status_d & ~pwdata[`IDC_IRQ_WIDTH-1:0];
      end
      status_d = status_d | events;                                    // [R4] [R5]
      // Built from next values, so the line moves in step with the status flops
      irq_d = |(status_d & mask_d);
   end

   // Interrupt flops
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         status_q <= '0;
         mask_q   <= '0;
         irq_q    <= 1'b0;
      end else begin
         status_q <= status_d;
         mask_q   <= mask_d;
         irq_q    <= irq_d;
      end
   end

   // Read mux; data is registered so it stands with pready for its one cycle
   always_comb begin
      periOffWord = 16'(periOff_q);
      rdata_d     = rdata_q;
      ready_d     = access;
      err_d       = access && !mapped;
      if (access && !pwrite) begin
         case (paddr)
            `IDC_CFG_ADDR:        rdata_d = {16'h0000, cfg_q};         // [R13]
            `IDC_APPLIED_ADDR:    rdata_d = {7'h00, periOffWord, applied_q};
            `IDC_IRQ_STATUS_ADDR: rdata_d = {30'h0, status_q};
            `IDC_IRQ_MASK_ADDR:   rdata_d = {30'h0, mask_q};
            default:              rdata_d = 32'h00000000;
         endcase
      end
   end

   // Bus answer flops; one wait state, pready never stretches
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 32'h00000000;
         ready_q <= 1'b0;
         err_q   <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         err_q   <= err_d;
      end
   end

   // Idle sequencer flops; nothing applies until an idle instruction or idle command write runs
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q   <= idle_domain_pkg::ST_RUN;
         snap_q    <= 16'h0000;
         applied_q <= '0;
         periOff_q <= '0;
      end else begin
         state_q   <= state_d;
         snap_q    <= snap_d;
         applied_q <= applied_d;
         periOff_q <= periOff_d;
      end
   end

   // Outputs straight from flops
   assign prdata        = rdata_q;
   assign pready        = ready_q;
   assign pslverr       = err_q;
   assign domainCtrl    = applied_q;
   assign peripheralOff = periOff_q;
   assign busErrorIrq   = irq_q;
endmodule

// ### design/idle_request_check.sv
// Legality check of an idle request set against the clock-generator rules
`timescale 1ns/1ns
`include "idle_domain_params.svh"
module idle_request_check (
   input  wire logic [15:0] cfgWord,   // Stored idle configuration
   output logic             badCombo,  // Request set is illegal
   output logic             stopClock  // Legal clock-generator stop
);
   logic clkReq;
   logic allSet;
   // Clock stop demands every companion bit; peripheral bit is exempt
   always_comb begin
      clkReq    = cfgWord[`IDC_BIT_CLKGEN];
      allSet    = ((cfgWord & `IDC_STOP_ALL_MASK) == `IDC_STOP_ALL_MASK);
      badCombo  = (clkReq && !allSet)                                   // [R4] [R5]
                  || (!clkReq && cfgWord[`IDC_BIT_CLK_CONFIRM]);        // [R3]
      stopClock = clkReq && allSet;                                     // [R3] [R6]
   end
endmodule

// ### dv/core_model.sv
// Core model that turns a bench request into an idle instruction pulse
`timescale 1ns/1ns
module core_model (
   input  wire logic core_clk,  // Clock
   input  wire logic rst,       // Reset
   input  wire logic go,        // Idle wanted
   output logic      idleInstr  // One-cycle pulse
);
   // Never two pulses in a row, as a real core spaces its idle instructions
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         idleInstr <= 1'b0;
      else
         idleInstr <= go && !idleInstr;
   end
endmodule

// ### dv/idle_domain_configuration_chk.sv
// Port checker for the idle configuration block
`timescale 1ns/1ns
`include "idle_domain_params.svh"
module idle_domain_configuration_chk (
   input wire logic        core_clk,   // Clock
   input wire logic        rst,        // Reset
   input wire logic        psel,       // Select
   input wire logic        penable,    // Access
   input wire logic        pwrite,     // Write
   input wire logic [11:0] paddr,      // Address
   input wire logic [31:0] pwdata,     // Write data
   input wire logic [3:0]  pstrb,      // Strobes
   input wire logic [31:0] prdata,     // Read data
   input wire logic        pready,     // Ready
   input wire logic        pslverr,    // Error
   input wire logic        idleInstr,  // Idle pulse
   input wire logic [15:0] peripheralIdleControl, // Flags
   input wire idle_domain_pkg::domain_ctrl_t domainCtrl, // Applied
   input wire logic [15:0] peripheralOff, // Held
   input wire logic        busErrorIrq // Irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Software idle trigger; any write there counts, which only widens the window
   wire logic swTrig = psel && penable && pwrite && paddr == `IDC_IDLE_CMD_ADDR;
   // Access taken by the slave
   sequence apbTake;
      psel && penable && !pready;
   endsequence
   // Quiet span longer than the apply latency
   sequence noIdle;
      (!idleInstr && !swTrig) [*5];
   endsequence
   a_ready_after_take: assert property (apbTake |=> pready) else $error("no ready after access");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
   a_ready_needs_access: assert property (!(psel && penable) |=> !pready) else $error("stray ready");
   a_error_on_unmapped: assert property (pready |-> pslverr == !(paddr inside {12'h004, 12'h008,
      12'h00c, 12'h010, 12'h014}))
      else $error("error flag wrong");
   a_reserved_reads_zero: assert property (
      pready && !pwrite && paddr == `IDC_CFG_ADDR |-> prdata[31:10] == 22'h0)
      else $error("reserved bits set");
   a_apply_only_on_idle: assert property (noIdle |=> $stable(domainCtrl)) else $error("apply without idle");
   a_stop_needs_all: assert property (domainCtrl.clockStop |-> &{domainCtrl[7:4], domainCtrl[2:0]})
      else $error("clock stop with domain on");
   a_periph_gated: assert property (!domainCtrl.periphGroupOff |-> peripheralOff == 16'h0)
      else $error("peripheral off without group bit");
   a_irq_clear_by_write: assert property ($fell(busErrorIrq) |-> psel && penable && pwrite)
      else $error("irq fell without write");
endmodule
bind idle_domain_configuration idle_domain_configuration_chk u_chk (
   .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .idleInstr(idleInstr), .peripheralIdleControl(peripheralIdleControl), .domainCtrl(domainCtrl),
   .peripheralOff(peripheralOff), .busErrorIrq(busErrorIrq));

// ### dv/tb.sv
// Self-checking bench for the idle configuration block
`timescale 1ns/1ns
`include "idle_domain_params.svh"
module tb;
   logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
   logic        er, pready, pslverr, idleInstr, busErrorIrq;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  pstrb = 4'hf;
   logic [15:0] peripheralIdleControl = 16'h00a5, peripheralOff;
   logic [8:0]  held = 9'h000;
   int          errors = 0, n_compared = 0;
   int          drop [8] = '{0, 1, 2, 5, 6, 7, 8, 9};
   logic [15:0] legal [11] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0020, 16'h0040,
                              16'h0080, 16'h0100, 16'h0000, 16'h03f7, 16'h03ff};
   idle_domain_pkg::domain_ctrl_t domainCtrl;
   idle_domain_configuration u_idle_domain_configuration (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .idleInstr(idleInstr), .peripheralIdleControl(peripheralIdleControl), .domainCtrl(domainCtrl),
      .peripheralOff(peripheralOff), .busErrorIrq(busErrorIrq));
   core_model u_core_model (.core_clk(core_clk), .rst(rst), .go(go), .idleInstr(idleInstr));
   always #25 core_clk = ~core_clk;
   // One APB transfer; the idle edge after release keeps strobes from doubling up
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic cmp(input string n, input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask
   // Store a set, confirm nothing moved, then issue the idle
   task automatic idle(input logic [15:0] c, input logic sw);
      apb(1'b1, `IDC_CFG_ADDR, {16'h0, c});
      cmp("ctrl before idle", 32'(domainCtrl), 32'(held));
      if (sw)
         apb(1'b1, `IDC_IDLE_CMD_ADDR, 32'h1);
      go <= !sw;
      @(posedge core_clk);
      go <= 1'b0;
      repeat (6) @(posedge core_clk);
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      apb(1'b0, `IDC_CFG_ADDR, 32'h0);
      cmp("cfg reset", rd, 32'h0);
      apb(1'b1, `IDC_CFG_ADDR, 32'hffff_ffff);
      apb(1'b0, `IDC_CFG_ADDR, 32'h0);
      cmp("reserved bits", rd, 32'h0000_03ff);
      // Upper lane only: the low byte must survive
      pstrb <= 4'h2;
      apb(1'b1, `IDC_CFG_ADDR, 32'h0);
      pstrb <= 4'hf;
      apb(1'b0, `IDC_CFG_ADDR, 32'h0);
      cmp("byte lanes", rd, 32'h0000_00ff);
      apb(1'b0, 12'h020, 32'h0);
      cmp("unmapped error", 32'(er), 32'h1);
      $display("test registers done");
      foreach (legal[i]) begin
         idle(legal[i], i == 0);
         held = {legal[i][4], legal[i][8:5], legal[i][3:0]};
         cmp("applied", 32'(domainCtrl), 32'(held));
         cmp("periph off", 32'(peripheralOff), legal[i][3] ? 32'h00a5 : 32'h0);
      end
      apb(1'b0, `IDC_APPLIED_ADDR, 32'h0);
      cmp("applied readback", rd, {7'h00, 16'h00a5, held});
      $display("test apply done");
      // A masked error latches but keeps the line low
      idle(16'h0010, 1'b0);
      cmp("masked irq", 32'(busErrorIrq), 32'h0);
      apb(1'b0, `IDC_IRQ_STATUS_ADDR, 32'h0);
      cmp("error status", rd & 32'h1, 32'h1);
      cmp("idle done status", rd & 32'h2, 32'h2);
      apb(1'b1, `IDC_IRQ_MASK_ADDR, 32'h1);
      cmp("unmasked irq", 32'(busErrorIrq), 32'h1);
      foreach (drop[i]) begin
         apb(1'b1, `IDC_IRQ_STATUS_ADDR, 32'h3);
         cmp("irq cleared", 32'(busErrorIrq), 32'h0);
         idle(16'h03f7 & ~(16'h0001 << drop[i]), 1'b0);
         cmp("ctrl kept", 32'(domainCtrl), 32'(held));
         cmp("irq raised", 32'(busErrorIrq), 32'h1);
      end
      // Confirm bit alone is an invalid pair as well
      apb(1'b1, `IDC_IRQ_STATUS_ADDR, 32'h3);
      cmp("irq cleared again", 32'(busErrorIrq), 32'h0);
      idle(16'h0200, 1'b0);
      cmp("confirm alone irq", 32'(busErrorIrq), 32'h1);
      cmp("confirm alone ctrl", 32'(domainCtrl), 32'(held));
      $display("test errors done");
      stop_test();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #200000;
      errors++;
      stop_test();
   end
endmodule

// ### shared/idle_domain_params.svh
// Offsets, bit positions, masks and reset value of the idle configuration block
`ifndef IDLE_DOMAIN_PARAMS_SVH
`define IDLE_DOMAIN_PARAMS_SVH
// Printed index 0x0001 is not a multiple of four: byte address is index times four
`define IDC_CFG_INDEX        12'h001
`define IDC_CFG_ADDR         12'h004
`define IDC_APPLIED_ADDR     12'h008
`define IDC_IRQ_STATUS_ADDR  12'h00c
`define IDC_IRQ_MASK_ADDR    12'h010
`define IDC_IDLE_CMD_ADDR    12'h014
`define IDC_CFG_WRITE_MASK   16'h03ff
`define IDC_CFG_RESET        16'h0000
`define IDC_STOP_ALL_MASK    16'h03f7
`define IDC_BIT_CORE         0
`define IDC_BIT_MASTER_PERIPHERAL_GROUP_IDLE_REQUEST  1
`define IDC_BIT_CACHE        2
`define IDC_BIT_PERIPH       3
`define IDC_BIT_CLKGEN       4
`define IDC_BIT_EXTMEM       5
`define IDC_BIT_IO_PORT      6
`define IDC_BIT_MASTER_PORT  7
`define IDC_BIT_CACHE_PORT   8
`define IDC_BIT_CLK_CONFIRM  9
`define IDC_IRQ_BUS_ERROR    0
`define IDC_IRQ_IDLE_DONE    1
`define IDC_IRQ_WIDTH        2
`endif

// ### shared/idle_domain_pkg.sv
// Types shared by the idle configuration block
package idle_domain_pkg;
   // Per-domain idle controls as applied after an idle instruction
   typedef struct packed {
      logic clockStop;
      logic cachePortOff;
      logic masterPortOff;
      logic ioPortOff;
      logic extMemOff;
      logic periphGroupOff;
      logic cacheOff;
      logic masterPeriphOff;
      logic coreOff;
   } domain_ctrl_t;
   typedef enum logic [1:0] {ST_RUN, ST_CHECK, ST_APPLY} idle_state_t;
endpackage
